// File: rtl/lfcc_defs.vh
`ifndef LFCC_DEFS_VH
`define LFCC_DEFS_VH
// ==========================================
// register byte offsets
`define LFCC_HF_START 12'h000
`define LFCC_HF_STOP 12'h004
`define LFCC_LF_START 12'h008
`define LFCC_LF_STOP 12'h00c
`define LFCC_CAL 12'h010
`define LFCC_CT_START 12'h014
`define LFCC_CT_STOP 12'h018
`define LFCC_EV_HF 12'h100
`define LFCC_EV_LF 12'h104
`define LFCC_EV_DONE 12'h10c
`define LFCC_EV_CAL_TIMER_TIMEOUT_EVENT 12'h110
`define LFCC_IRQ_ENABLE_SET 12'h304
`define LFCC_IRQ_ENABLE_CLEAR 12'h308
`define LFCC_HF_RUN 12'h408
`define LFCC_HF_STAT 12'h40c
`define LFCC_LF_RUN 12'h414
`define LFCC_LF_STAT 12'h418
`define LFCC_SRC_COPY 12'h41c
`define LFCC_SRC_SEL 12'h518
`define LFCC_CAL_TIMER_INTERVAL 12'h538
// ==========================================
// source field codes and field positions
`define LFCC_SRC_RC 2'h0
`define LFCC_SRC_XTAL 2'h1
`define LFCC_SRC_SYNT 2'h2
`define LFCC_BYPASS_BIT 16
`define LFCC_EXTERNAL_BIT 17
`define LFCC_STATE_BIT 16
// interrupt enable bit positions
`define LFCC_IRQ_HF 0
`define LFCC_IRQ_LF 1
`define LFCC_IRQ_DONE 3
`define LFCC_IRQ_CAL_TIMER_TIMEOUT_EVENT 4
// ==========================================
// reset values and timing
`define LFCC_CAL_TIMER_INTERVAL_RESET 7'h00
`define LFCC_LF_FREQ_HZ 32768
`define LFCC_PCLK_HZ 125000000
`define LFCC_LF_DIV (`LFCC_PCLK_HZ / `LFCC_LF_FREQ_HZ)
`define LFCC_CAL_CYCLES 16'h0200
`endif

// File: rtl/lfcc_top.v
`timescale 1ns/1ps
`include "lfcc_defs.vh"
module lfcc_top #(
	parameter LF_DIV = `LFCC_LF_DIV, // pclk cycles per low frequency tick
	parameter CAL_CYCLES = `LFCC_CAL_CYCLES, // calibration length in ticks of pclk
	parameter CT_STEP_TICKS = 8'd8 // low ticks per timer step (0.25 s scaled)
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire system_off,
	input wire high_freq_crystal_osc_ready,
	input wire low_freq_crystal_osc_ready,
	output reg irq,
	output reg high_freq_crystal_osc_en,
	output reg high_freq_clock_req,
	output reg low_freq_rc_osc_en,
	output reg low_freq_crystal_osc_en,
	output reg low_freq_clock_active,
	output reg [1:0] low_freq_clock_src
);
	// ==========================================
	// bus decode
	// access cycles arrive as psel and penable both high; the first one
	// launches the registered pready, the second closes the transfer
	// writes land only on the closing edge, where the master sees pready,
	// so a master that waits longer never sees a write land early
	wire acc = psel & penable & ~pready; // access cycle before the answer
	wire xfer = psel & penable & pready; // closing edge of a transfer
	wire wr = xfer & pwrite; // write strobe, one cycle per transfer
	wire [31:0] wd = pwdata; // write data
	// task strobes, one cycle per written 1
	// only bit 0 of a task word matters; the other bits are ignored
	// writing 0 to a task register is a harmless no-op
	// task registers hold nothing and always read back as zero
	wire t_hf_start = wr && paddr == `LFCC_HF_START && wd[0];
	wire t_hf_stop = wr && paddr == `LFCC_HF_STOP && wd[0];
	wire t_lf_start = wr && paddr == `LFCC_LF_START && wd[0];
	wire t_lf_stop = wr && paddr == `LFCC_LF_STOP && wd[0];
	wire t_cal = wr && paddr == `LFCC_CAL && wd[0];
	wire t_ct_start = wr && paddr == `LFCC_CT_START && wd[0];
	wire t_ct_stop = wr && paddr == `LFCC_CT_STOP && wd[0];
	// ==========================================
	// state registers
	// everything below lives in the pclk domain; the slow clock exists
	// only as the one-cycle tick enable further down
	// names ending in _r are flops; other internal names are combinational
	reg [1:0] src_r; // source field
	reg ext_r; // external bit
	reg byp_r; // bypass bit
	reg [19:0] copy_r; // snapshot of selection
	reg [6:0] cal_timer_interval_r; // timer interval
	reg hf_run_r; // high start requested
	reg hf_on_r; // high crystal running
	reg lf_run_r; // low start requested
	reg lf_on_r; // low clock running
	reg lf_xtal_r; // running from crystal
	reg ev_hf_r, ev_lf_r, ev_done_r, ev_cal_timer_timeout_event_r; // event flags
	reg [4:0] inten_r; // interrupt enables
	reg cal_busy_r; // calibration running
	reg [15:0] cal_cnt_r; // calibration length
	reg ct_run_r; // timer counting
	reg [6:0] ct_cnt_r; // timer value
	reg [7:0] ct_tick_r; // ticks within a step
	reg [15:0] div_r; // low tick divider
	reg tick_r; // low frequency tick
	reg [2:0] hf_sync_r, lf_sync_r; // pin synchronisers
	// ==========================================
	// ready inputs through three flops
	// the oscillator ready levels settle on their own time, not on pclk
	// the first flop may go metastable and is read by the second only
	// a slow ready edge can make the second and third disagree for a cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hf_sync_r <= 3'h0;
			lf_sync_r <= 3'h0;
		end else begin
			hf_sync_r <= {hf_sync_r[1:0], high_freq_crystal_osc_ready};
			lf_sync_r <= {lf_sync_r[1:0], low_freq_crystal_osc_ready};
		end
	end
	// second and third agree before a change counts
	// the filtered level holds its old value while the two disagree,
	// so one odd sample never toggles the running state
	// cost: about four cycles of latency on every ready change
	reg hf_rdy_r, lf_rdy_r; // filtered ready levels
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hf_rdy_r <= 1'b0;
			lf_rdy_r <= 1'b0;
		end else begin
			if (hf_sync_r[1] == hf_sync_r[2])
				hf_rdy_r <= hf_sync_r[2];
			if (lf_sync_r[1] == lf_sync_r[2])
				lf_rdy_r <= lf_sync_r[2];
		end
	end
	// ==========================================
	// low frequency tick enable
	// stands in for the slow clock: one pulse every LF_DIV cycles
	// the divider runs free; only the pulse is gated by the running state,
	// so the timer freezes while the slow clock is stopped
	// the phase of the first tick after a start is not defined
	// LF_DIV is scaled down in simulation to keep runs short
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 16'h0;
			tick_r <= 1'b0;
		end else if (div_r == LF_DIV[15:0] - 16'h1) begin
			div_r <= 16'h0;
			tick_r <= lf_on_r; // only while the clock runs
		end else begin
			div_r <= div_r + 16'h1;
			tick_r <= 1'b0;
		end
	end
	// ==========================================
	// configuration registers
	// the selection may only change while the slow clock is stopped;
	// a write while running is still stored, but the running source follows
	// the snapshot taken at start, so nothing switches under the clock
	// interrupt enables are set and cleared through two separate words,
	// so software never needs a read-modify-write on them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_r <= `LFCC_SRC_RC;
			ext_r <= 1'b0;
			byp_r <= 1'b0;
			cal_timer_interval_r <= `LFCC_CAL_TIMER_INTERVAL_RESET;
			copy_r <= 20'h0;
			inten_r <= 5'h0;
		end else begin
			// rc 0, crystal 1, synth 2
			if (wr && paddr == `LFCC_SRC_SEL) begin
				src_r <= wd[1:0];
				ext_r <= wd[`LFCC_EXTERNAL_BIT];
				byp_r <= wd[`LFCC_BYPASS_BIT];
			end
			if (wr && paddr == `LFCC_CAL_TIMER_INTERVAL)
				cal_timer_interval_r <= wd[6:0];
			if (t_lf_start)
				copy_r <= {ext_r, byp_r, 14'h0, src_r};
			if (wr && paddr == `LFCC_IRQ_ENABLE_SET)
				inten_r <= inten_r | wd[4:0];
			else if (wr && paddr == `LFCC_IRQ_ENABLE_CLEAR)
				inten_r <= inten_r & ~wd[4:0];
		end
	end
	// ==========================================
	// high crystal control
	// the run flag shows only that the start task was seen; the running
	// flag waits for the filtered ready level as well
	// off mode drops both at once, without waiting for a stop task
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hf_run_r <= 1'b0;
			hf_on_r <= 1'b0;
		end else if (system_off) begin
			hf_run_r <= 1'b0;
			hf_on_r <= 1'b0;
		end else begin
			if (t_hf_start)
				hf_run_r <= 1'b1;
			else if (t_hf_stop)
				hf_run_r <= 1'b0;
			hf_on_r <= hf_run_r & hf_rdy_r;
		end
	end
	// ==========================================
	// low clock control and source switch-over
	// priority: off mode, then stop, then start, then the crystal handover
	// a crystal start always begins on the rc source and moves over once
	// the crystal ready level has passed the filter; the handover is one-way
	// until the next stop or start
	// a stop while the crystal is still starting simply abandons it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lf_run_r <= 1'b0;
			lf_on_r <= 1'b0;
			lf_xtal_r <= 1'b0;
		end else if (system_off) begin
			lf_run_r <= 1'b0;
			lf_on_r <= 1'b0;
			lf_xtal_r <= 1'b0;
		end else if (t_lf_stop) begin
			lf_run_r <= 1'b0;
			lf_on_r <= 1'b0;
			lf_xtal_r <= 1'b0;
		end else if (t_lf_start) begin
			lf_run_r <= 1'b1;
			lf_on_r <= 1'b1;
			lf_xtal_r <= 1'b0;
		end else if (lf_on_r && copy_r[1:0] == `LFCC_SRC_XTAL && lf_rdy_r) begin
			lf_xtal_r <= 1'b1;
		end
	end
	// ==========================================
	// calibration sequence
	// a calibrate task is dropped unless the rc source is running and the
	// high crystal is already up; nothing is queued for later
	// the length is a fixed count of pclk cycles standing in for the
	// measurement against the high clock reference
	// losing the slow clock mid-way aborts without a done event
	// the high clock stays requested for the whole calibration
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_busy_r <= 1'b0;
			cal_cnt_r <= 16'h0;
		end else if (system_off) begin
			cal_busy_r <= 1'b0;
		end else if (!cal_busy_r) begin
			// needs running rc and a running high crystal
			if (t_cal && lf_on_r && copy_r[1:0] == `LFCC_SRC_RC && hf_on_r) begin
				cal_busy_r <= 1'b1;
				cal_cnt_r <= CAL_CYCLES[15:0];
			end
		end else if (cal_cnt_r == 16'h0 || !lf_on_r) begin
			cal_busy_r <= 1'b0;
		end else begin
			cal_cnt_r <= cal_cnt_r - 16'h1;
		end
	end
	wire cal_done = cal_busy_r && cal_cnt_r == 16'h0;
	// ==========================================
	// calibration interval timer, one step per CT_STEP_TICKS ticks
	// a start reloads the interval every time, even while counting
	// a stop freezes the value; only the next start reloads it
	// at zero the timeout flag fires for one cycle and the timer halts,
	// so an interval of zero times out right after the start
	// each task acts on the edge it is written, however close together tasks come
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ct_run_r <= 1'b0;
			ct_cnt_r <= 7'h0;
			ct_tick_r <= 8'h0;
		end else if (t_ct_start) begin
			ct_run_r <= 1'b1;
			ct_cnt_r <= cal_timer_interval_r;
			ct_tick_r <= 8'h0;
		end else if (t_ct_stop || system_off) begin
			ct_run_r <= 1'b0;
		end else if (ct_run_r && ct_cnt_r == 7'h0) begin
			ct_run_r <= 1'b0;
		end else if (ct_run_r && tick_r) begin
			if (ct_tick_r == CT_STEP_TICKS - 8'h1) begin
				ct_tick_r <= 8'h0;
				ct_cnt_r <= ct_cnt_r - 7'h1;
			end else begin
				ct_tick_r <= ct_tick_r + 8'h1;
			end
		end
	end
	wire cal_timer_timeout_event = ct_run_r && ct_cnt_r == 7'h0;
	// ==========================================
	// event flags, set wins over a software clear
	// each flag holds until software writes it; bit 0 of the write is the
	// new value, so writing 1 can also raise a flag for testing
	// a set that lands on the same edge as a clear keeps the flag up,
	// so an event is never lost to a late clear
	// rc and synth sources report started at once; the crystal reports
	// when its ready level has passed the filter
	wire lf_started = lf_on_r && !lf_xtal_r && copy_r[1:0] == `LFCC_SRC_XTAL && lf_rdy_r;
	wire lf_started_other = t_lf_start && src_r != `LFCC_SRC_XTAL;
	wire hf_started = hf_run_r && hf_rdy_r && !hf_on_r;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_hf_r <= 1'b0;
			ev_lf_r <= 1'b0;
			ev_done_r <= 1'b0;
			ev_cal_timer_timeout_event_r <= 1'b0;
		end else begin
			if (hf_started)
				ev_hf_r <= 1'b1;
			else if (wr && paddr == `LFCC_EV_HF)
				ev_hf_r <= wd[0];
			if (lf_started || lf_started_other)
				ev_lf_r <= 1'b1;
			else if (wr && paddr == `LFCC_EV_LF)
				ev_lf_r <= wd[0];
			if (cal_done)
				ev_done_r <= 1'b1;
			else if (wr && paddr == `LFCC_EV_DONE)
				ev_done_r <= wd[0];
			if (cal_timer_timeout_event)
				ev_cal_timer_timeout_event_r <= 1'b1;
			else if (wr && paddr == `LFCC_EV_CAL_TIMER_TIMEOUT_EVENT)
				ev_cal_timer_timeout_event_r <= wd[0];
		end
	end
	// ==========================================
	// oscillator outputs and interrupt
	// every output is a flop, one cycle behind the state that drives it
	// off mode masks the enables directly so they drop one cycle after
	// off is seen, whatever state the control flops are in
	// the source output is the source actually clocking right now
	// irq is a level: it stays up while any enabled flag is set
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			high_freq_crystal_osc_en <= 1'b0;
			high_freq_clock_req <= 1'b0;
			low_freq_rc_osc_en <= 1'b0;
			low_freq_crystal_osc_en <= 1'b0;
			low_freq_clock_active <= 1'b0;
			low_freq_clock_src <= `LFCC_SRC_RC;
		end else begin
			irq <= (ev_hf_r & inten_r[`LFCC_IRQ_HF]) | (ev_lf_r & inten_r[`LFCC_IRQ_LF])
				| (ev_done_r & inten_r[`LFCC_IRQ_DONE])
				| (ev_cal_timer_timeout_event_r & inten_r[`LFCC_IRQ_CAL_TIMER_TIMEOUT_EVENT]);
			high_freq_crystal_osc_en <= hf_run_r & ~system_off;
			// synth source and calibration both hold the high clock
			high_freq_clock_req <= ~system_off & (cal_busy_r
				| (lf_on_r & copy_r[1:0] == `LFCC_SRC_SYNT));
			// rc runs for rc source and during crystal start-up
			low_freq_rc_osc_en <= lf_on_r & ~system_off & (copy_r[1:0] == `LFCC_SRC_RC
				| (copy_r[1:0] == `LFCC_SRC_XTAL & ~lf_xtal_r));
			low_freq_crystal_osc_en <= lf_on_r & ~system_off & copy_r[1:0] == `LFCC_SRC_XTAL;
			low_freq_clock_active <= lf_on_r & ~system_off;
			low_freq_clock_src <= (copy_r[1:0] == `LFCC_SRC_XTAL && !lf_xtal_r)
				? `LFCC_SRC_RC : copy_r[1:0];
		end
	end
	// ==========================================
	// read mux
	// unmapped addresses answer with an error and read as zero
	// read-only words ignore writes but answer without error
	// status words carry the running flag in bit 16
	// both enable words read back the same enable set
	reg [31:0] rd; // read value
	reg hit; // mapped address
	always @* begin
		rd = 32'h0;
		hit = 1'b1;
		case (paddr)
			`LFCC_HF_START, `LFCC_HF_STOP, `LFCC_LF_START, `LFCC_LF_STOP,
			`LFCC_CAL, `LFCC_CT_START, `LFCC_CT_STOP: rd = 32'h0;
			`LFCC_EV_HF: rd = {31'h0, ev_hf_r};
			`LFCC_EV_LF: rd = {31'h0, ev_lf_r};
			`LFCC_EV_DONE: rd = {31'h0, ev_done_r};
			`LFCC_EV_CAL_TIMER_TIMEOUT_EVENT: rd = {31'h0, ev_cal_timer_timeout_event_r};
			`LFCC_IRQ_ENABLE_SET, `LFCC_IRQ_ENABLE_CLEAR: rd = {27'h0, inten_r};
			`LFCC_HF_RUN: rd = {31'h0, hf_run_r};
			`LFCC_HF_STAT: rd = {15'h0, hf_on_r, 16'h1};
			`LFCC_LF_RUN: rd = {31'h0, lf_run_r};
			`LFCC_LF_STAT: rd = {15'h0, lf_on_r, 14'h0, low_freq_clock_src};
			`LFCC_SRC_COPY: rd = {12'h0, copy_r};
			`LFCC_SRC_SEL: rd = {14'h0, ext_r, byp_r, 14'h0, src_r};
			`LFCC_CAL_TIMER_INTERVAL: rd = {25'h0, cal_timer_interval_r};
			default: hit = 1'b0;
		endcase
	end
	// one wait state: ready in the second access cycle
	// pready, pslverr and read data all come from flops and stand for
	// exactly one cycle; acc is false while pready is up, but a request held
	// past the answer is answered again two cycles later
	// read data is captured in the first access cycle, one edge before the
	// master takes it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (acc) begin
			pready <= 1'b1;
			pslverr <= ~hit;
			prdata <= pwrite ? 32'h0 : rd;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
	end
endmodule // lfcc_top

// File: tb/lfcc_assertions.sv
`timescale 1ns/1ps
// ====
// port checker
module lfcc_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire system_off,
	input wire high_freq_crystal_osc_ready,
	input wire low_freq_crystal_osc_ready,
	input wire irq,
	input wire high_freq_crystal_osc_en,
	input wire high_freq_clock_req,
	input wire low_freq_rc_osc_en,
	input wire low_freq_crystal_osc_en,
	input wire low_freq_clock_active,
	input wire [1:0] low_freq_clock_src
);
	// task write taken this edge
	wire tk = psel && penable && pwrite && pready && !system_off && pwdata[0];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_answer_next: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after access");
	a_reset_src_rc: assert property ($rose(presetn) |-> low_freq_clock_src == 2'h0)
		else $error("source not rc after reset");
	a_start_runs: assert property (tk && paddr == 12'h008 |-> ##[1:2] low_freq_clock_active)
		else $error("start did not run");
	a_stop_halts: assert property (tk && paddr == 12'h00c |-> ##[1:2] !low_freq_clock_active)
		else $error("stop did not halt");
	a_hf_start_on: assert property (tk && paddr == 12'h000 |-> ##[1:2] high_freq_crystal_osc_en)
		else $error("hf crystal not enabled");
	a_off_all_low: assert property (system_off ##1 system_off |->
		!low_freq_rc_osc_en && !low_freq_crystal_osc_en && !low_freq_clock_active)
		else $error("source on in off mode");
	a_xtal_on_rc: assert property (low_freq_clock_active && low_freq_crystal_osc_en &&
		!low_freq_crystal_osc_ready |-> low_freq_clock_src != 2'h1)
		else $error("crystal used before ready");
	a_xtal_switch: assert property ((low_freq_clock_active && low_freq_crystal_osc_ready)[*8]
		|-> low_freq_clock_src == 2'h1)
		else $error("no switch to crystal");
	a_synth_hf_req: assert property ((low_freq_clock_active && low_freq_clock_src == 2'h2)[*2]
		|-> high_freq_clock_req)
		else $error("synth without hf request");
	a_src_legal: assert property (low_freq_clock_src != 2'h3)
		else $error("illegal source code");
endmodule // lfcc_checker
bind lfcc_top lfcc_checker lfcc_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .system_off, .high_freq_crystal_osc_ready,
	.low_freq_crystal_osc_ready, .irq, .high_freq_crystal_osc_en, .high_freq_clock_req,
	.low_freq_rc_osc_en, .low_freq_crystal_osc_en, .low_freq_clock_active,
	.low_freq_clock_src);

// File: tb/lfcc_osc_model.sv
`timescale 1ns/1ps
// ====
// oscillators: ready after a start delay, low once disabled
module lfcc_osc_model (
	input wire pclk,
	input wire presetn,
	input wire slow,
	input wire hf_en,
	input wire lf_en,
	output wire hf_ready,
	output wire lf_ready
);
	reg [5:0] hf_cnt_r; // hf on time
	reg [5:0] lf_cnt_r; // lf on time
	wire [5:0] dly = slow ? 6'h30 : 6'h02; // slow or prompt start
	assign hf_ready = hf_en && hf_cnt_r >= dly;
	assign lf_ready = lf_en && lf_cnt_r >= dly;
	// saturating start-up counters
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hf_cnt_r <= 6'h00;
			lf_cnt_r <= 6'h00;
		end else begin
			hf_cnt_r <= !hf_en ? 6'h00 : hf_cnt_r + {5'h00, hf_cnt_r != 6'h3f};
			lf_cnt_r <= !lf_en ? 6'h00 : lf_cnt_r + {5'h00, lf_cnt_r != 6'h3f};
		end
	end
endmodule // lfcc_osc_model

// File: tb/lfcc_tb_top.sv
`timescale 1ns/1ps
`include "lfcc_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module lfcc_tb_top;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} lfcc_row_t;
	logic pclk, presetn, psel, penable, pwrite, system_off, slow, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire [31:0] prdata;
	wire pready, pslverr, irq, hf_en, hf_req, rc_en, lf_en, lf_act, hf_rdy, lf_rdy;
	wire [1:0] lf_src;
	int n_fail = 0, n_tests = 0;
	lfcc_row_t rows[6] = '{'{12'h518, 32'h1, 32'h1, 1'b0}, '{12'h518, 32'h30001, 32'h30001, 1'b0},
		'{12'h518, 32'h0, 32'h0, 1'b0}, '{12'h538, 32'hff, 32'h7f, 1'b0},
		'{12'h418, 32'h10003, 32'h0, 1'b0}, '{12'h0f0, 32'h5, 32'h0, 1'b1}};
	lfcc_top #(.LF_DIV(4), .CAL_CYCLES(8), .CT_STEP_TICKS(8'd2)) lfcc_top_i (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .system_off,
		.high_freq_crystal_osc_ready(hf_rdy), .low_freq_crystal_osc_ready(lf_rdy), .irq,
		.high_freq_crystal_osc_en(hf_en), .high_freq_clock_req(hf_req),
		.low_freq_rc_osc_en(rc_en), .low_freq_crystal_osc_en(lf_en),
		.low_freq_clock_active(lf_act), .low_freq_clock_src(lf_src));
	lfcc_osc_model lfcc_osc_model_i (.pclk, .presetn, .slow, .hf_en, .lf_en,
		.hf_ready(hf_rdy), .lf_ready(lf_rdy));
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	// ====
	// apb master, waits for pready under a bound
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (k == 20) begin
			n_fail++;
			tally_and_finish;
		end
	endtask
	task chk_rd(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0);
		`CHK(rd, e)
	endtask
	task poll(input logic [11:0] a); // bounded wait for an event flag
		int k;
		for (k = 0; k < 100; k++) begin
			apb(0, a, 0);
			if (rd[0] === 1'b1) break;
		end
		`CHK(rd[0], 1'b1)
		if (rd[0] !== 1'b1) tally_and_finish;
	endtask
	// start a source, check status, stop it
	task run_src(input logic [31:0] d);
		apb(1, `LFCC_SRC_SEL, d);
		apb(1, `LFCC_EV_LF, 0);
		apb(1, `LFCC_LF_START, 1);
		chk_rd(`LFCC_LF_RUN, 1);
		chk_rd(`LFCC_LF_STAT, {15'h0, 1'b1, 14'h0, (d[1:0] == 2'h1) ? 2'h0 : d[1:0]});
		chk_rd(`LFCC_SRC_COPY, d);
		poll(`LFCC_EV_LF);
		repeat (12) @(posedge pclk);
		chk_rd(`LFCC_LF_STAT, {15'h0, 1'b1, 14'h0, d[1:0]});
		`CHK(lf_src, d[1:0])
		if (d[1:0] == 2'h2) `CHK(hf_req, 1'b1)
		apb(1, `LFCC_LF_STOP, 1);
		apb(0, `LFCC_LF_STAT, 0);
		`CHK(rd[16], 1'b0)
		$display("source %h done", d);
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ====
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, system_off, slow, paddr, pwdata} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		chk_rd(`LFCC_SRC_SEL, 0);
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].d);
			apb(0, rows[i].a, 0);
			`CHK(er, rows[i].er)
			if (!rows[i].er) `CHK(rd, rows[i].e)
		end
		$display("register rows done");
		slow <= 1;
		run_src(0);
		run_src(1);
		run_src(32'h20001);
		run_src(32'h30001);
		run_src(2);
		slow <= 0;
		run_src(1);
		apb(1, `LFCC_HF_START, 1);
		poll(`LFCC_EV_HF);
		chk_rd(`LFCC_HF_STAT, 32'h10001);
		apb(1, `LFCC_SRC_SEL, 0);
		apb(1, `LFCC_LF_START, 1);
		apb(1, `LFCC_IRQ_ENABLE_SET, 32'h18);
		apb(1, `LFCC_CAL, 1);
		poll(`LFCC_EV_DONE);
		`CHK(irq, 1'b1)
		apb(1, `LFCC_EV_DONE, 0);
		repeat (8) @(posedge pclk);
		`CHK(irq, 1'b0)
		apb(1, `LFCC_CAL_TIMER_INTERVAL, 3);
		apb(1, `LFCC_CT_START, 1);
		chk_rd(`LFCC_EV_CAL_TIMER_TIMEOUT_EVENT, 0);
		poll(`LFCC_EV_CAL_TIMER_TIMEOUT_EVENT);
		apb(1, `LFCC_EV_CAL_TIMER_TIMEOUT_EVENT, 0);
		repeat (60) @(posedge pclk);
		chk_rd(`LFCC_EV_CAL_TIMER_TIMEOUT_EVENT, 0);
		apb(1, `LFCC_CAL_TIMER_INTERVAL, 10);
		apb(1, `LFCC_CT_START, 1);
		repeat (8) @(posedge pclk);
		apb(1, `LFCC_CT_STOP, 1);
		repeat (120) @(posedge pclk);
		chk_rd(`LFCC_EV_CAL_TIMER_TIMEOUT_EVENT, 0);
		apb(1, `LFCC_IRQ_ENABLE_CLEAR, 32'h18);
		$display("calibration and timer done");
		system_off <= 1;
		repeat (3) @(posedge pclk);
		`CHK({lf_act, rc_en, lf_en}, 3'h0)
		system_off <= 0;
		apb(1, `LFCC_LF_STOP, 1);
		apb(1, `LFCC_SRC_SEL, 2);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		chk_rd(`LFCC_SRC_SEL, 0);
		$display("off mode and reset done");
		tally_and_finish;
	end
endmodule // lfcc_tb_top
